// ---- shared/waveform_peak_mode_pkg.sv ----
package waveform_peak_mode_pkg;
   // *****************************************************
   // Widths
   // *****************************************************
   localparam int SAMPLE_W = 24;
   localparam int ADR_W = 8;
   localparam int IDX_W = 6;
   localparam int DIV_W = 12;
   localparam int IRQ_W = 3;

   // *****************************************************
   // Register indices (byte address is four times these)
   // *****************************************************
   localparam logic [IDX_W-1:0] IDX_MEAS_MODE = 6'h14;
   localparam logic [IDX_W-1:0] IDX_WAVE_MODE = 6'h15;
   localparam logic [IDX_W-1:0] IDX_VOLT_THR = 6'h18;
   localparam logic [IDX_W-1:0] IDX_CURR_THR = 6'h19;
   localparam logic [IDX_W-1:0] IDX_PEAK_VOLT = 6'h1a;
   localparam logic [IDX_W-1:0] IDX_PEAK_CURR = 6'h1b;
   localparam logic [IDX_W-1:0] IDX_HALF_CYC = 6'h1c;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h21;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h22;

   // *****************************************************
   // Field positions and reset values
   // *****************************************************
   localparam int PKSEL_LSB = 2;
   localparam int PKMON_LSB = 5;
   localparam int SAMPLE_PHASE_SELECT_LSB = 0;
   localparam int SRC_LSB = 2;
   localparam int RATE_LSB = 5;
   localparam int APPARENT_BIT = 7;
   localparam logic [7:0] MEAS_MODE_RST = 8'hfc;
   localparam logic [7:0] WAVE_MODE_RST = 8'h00;
   localparam logic [2:0] PKSEL_RST = 3'h7;
   localparam int IRQ_WIN = 0;
   localparam int IRQ_VPK = 1;
   localparam int IRQ_IPK = 2;

   // *****************************************************
   // Sample rate: master clock / 3 / (128 << code)
   // *****************************************************
   localparam int PRE_DIV = 3;
   localparam int BASE_DIV = 128;

   // *****************************************************
   // Codes
   // *****************************************************
   typedef enum logic [1:0] {PH_A = 2'h0, PH_B = 2'h1, PH_C = 2'h2, PH_RSVD = 2'h3} phase_e;
   typedef enum logic [2:0] {
      SRC_CURR = 3'h0, SRC_VOLT = 3'h1, SRC_ACT = 3'h2, SRC_REACT = 3'h3, SRC_APP = 3'h4
   } source_e;

   // *****************************************************
   // Carriers
   // *****************************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic [SAMPLE_W-1:0] v_abs;
      logic [SAMPLE_W-1:0] i_abs;
   } phase_sample_s;

   typedef struct packed {
      logic ok;
      logic [1:0] phase;
      logic [2:0] source;
      logic strobe;
   } wave_sel_s;
endpackage : waveform_peak_mode_pkg

// ---- design/waveform_peak_mode_config.sv ----
// Notes on behaviour
// - Peak select has three bits at 2..4 resetting to 7, and bit 2 lets phase A feed both peaks.
// - Peaks are searched over the programmed count of half-line cycles and replaced at its end.
// - Bit 3 of peak select enables phase B peak detection and bit 4 phase C.
// - Voltage and current peaks are tracked independently, so they may come from different phases.
// - Monitor select has three bits at 5..7 resetting to 7, one per phase, in any mix.
// - Each monitored phase compares absolute samples with the voltage and current thresholds.
// - Sample phase select at bits 0..1 resets to 0; codes pick A, B, C, and 3 is reserved.
// - Sample source at bits 2..4 resets to 0: current, voltage, active, reactive, apparent.
// - Sample rate at bits 5..6 divides the master clock by 3 and then by 128, 256, 512 or 1024.
// - Waveform mode bit 7 steers the second pulse output to apparent instead of reactive power.
`timescale 1ns/1ns
module waveform_peak_mode_config
   import waveform_peak_mode_pkg::*;
#(
   parameter int HC_W = 16
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wb_req_s wb_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic sample_valid_i,
   input wire phase_sample_s [2:0] samples_i,
   input wire logic half_cycle_i,
   output wave_sel_s wave_o,
   output logic pulse2_apparent_o,
   output logic irq_o
);

   // *****************************************************
   // State
   // *****************************************************
   typedef enum logic [1:0] {WIN_IDLE = 2'b01, WIN_RUN = 2'b10} win_e;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [7:0] meas_mode;
      logic [7:0] wave_mode;
      logic [HC_W-1:0] half_cyc;
      logic [SAMPLE_W-1:0] volt_thr;
      logic [SAMPLE_W-1:0] curr_thr;
      logic [SAMPLE_W-1:0] peak_volt;
      logic [SAMPLE_W-1:0] peak_curr;
      logic [SAMPLE_W-1:0] run_volt;
      logic [SAMPLE_W-1:0] run_curr;
      logic [HC_W-1:0] hc_seen;
      win_e win;
      logic [DIV_W-1:0] div;
      logic [IRQ_W-1:0] stat;
      logic [IRQ_W-1:0] en;
      logic irq;
      logic pulse2_app;
      wave_sel_s wave;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   logic [IDX_W-1:0] idx;
   logic bus_hit;
   logic win_end;
   logic [2:0] pksel;
   logic [2:0] pkmon;
   logic [DIV_W-1:0] div_lim;

   // Byte lanes merged into a register word
   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // *****************************************************
   // Decode helpers
   // *****************************************************
   assign idx = wb_i.adr[ADR_W-1:2];
   assign bus_hit = wb_i.cyc && wb_i.stb && !s_r.ack;
   assign pksel = s_r.meas_mode[PKSEL_LSB +: 3];
   assign pkmon = s_r.meas_mode[PKMON_LSB +: 3];
   // Window closes on the last counted half cycle
   assign win_end = (s_r.win == WIN_RUN) && half_cycle_i
      && ((s_r.hc_seen + HC_W'(1)) >= s_r.half_cyc);
   // Divider limit, computed as int then cut to DIV_W; the largest, 3072, still fits
   assign div_lim = DIV_W'(PRE_DIV * (BASE_DIV << s_r.wave_mode[RATE_LSB +: 2])) - DIV_W'(1);

   // *****************************************************
   // Next state
   // *****************************************************
   always_comb
   begin
      logic [31:0] wr;
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      logic [SAMPLE_W-1:0] vmax;
      logic [SAMPLE_W-1:0] imax;
      wr = '0;
      ev = '0;
      clr = '0;
      vmax = s_r.run_volt;
      imax = s_r.run_curr;
      s_nxt = s_r;
      s_nxt.ack = 1'b0;

      // Bus access; every address answers, unmapped ones read zero
      if (bus_hit)
      begin
         s_nxt.ack = 1'b1;
         s_nxt.rdat = '0;
         unique case (idx)
            IDX_MEAS_MODE: s_nxt.rdat = {24'h0, s_r.meas_mode};
            IDX_WAVE_MODE: s_nxt.rdat = {24'h0, s_r.wave_mode};
            IDX_VOLT_THR: s_nxt.rdat = 32'(s_r.volt_thr);
            IDX_CURR_THR: s_nxt.rdat = 32'(s_r.curr_thr);
            IDX_PEAK_VOLT: s_nxt.rdat = 32'(s_r.peak_volt);
            IDX_PEAK_CURR: s_nxt.rdat = 32'(s_r.peak_curr);
            IDX_HALF_CYC: s_nxt.rdat = 32'(s_r.half_cyc);
            IDX_IRQ_STAT: s_nxt.rdat = 32'(s_r.stat);
            IDX_IRQ_EN: s_nxt.rdat = 32'(s_r.en);
            default: s_nxt.rdat = '0;
         endcase
         if (wb_i.we)
         begin
            unique case (idx)
               IDX_MEAS_MODE:
               begin
                  wr = merge_bytes(32'(s_r.meas_mode), wb_i.dat, wb_i.sel);
                  s_nxt.meas_mode = wr[7:0];
               end
               IDX_WAVE_MODE:
               begin
                  wr = merge_bytes(32'(s_r.wave_mode), wb_i.dat, wb_i.sel);
                  s_nxt.wave_mode = wr[7:0];
               end
               IDX_VOLT_THR:
               begin
                  wr = merge_bytes(32'(s_r.volt_thr), wb_i.dat, wb_i.sel);
                  s_nxt.volt_thr = wr[SAMPLE_W-1:0];
               end
               IDX_CURR_THR:
               begin
                  wr = merge_bytes(32'(s_r.curr_thr), wb_i.dat, wb_i.sel);
                  s_nxt.curr_thr = wr[SAMPLE_W-1:0];
               end
               IDX_HALF_CYC:
               begin
                  wr = merge_bytes(32'(s_r.half_cyc), wb_i.dat, wb_i.sel);
                  s_nxt.half_cyc = wr[HC_W-1:0];
               end
               IDX_IRQ_CLR: clr = wb_i.sel[0] ? wb_i.dat[IRQ_W-1:0] : '0;
               IDX_IRQ_EN:
               begin
                  if (wb_i.sel[0])
                  begin
                     s_nxt.en = wb_i.dat[IRQ_W-1:0];
                  end
               end
               default: ;
            endcase
         end
      end

      // Phase B and C join the search only when their bits are set
      // Voltage and current maxima are kept apart
      if (sample_valid_i)
      begin
         for (int p = 0; p < 3; p++)
         begin
            if (pksel[p] && samples_i[p].v_abs > vmax)
            begin
               vmax = samples_i[p].v_abs;
            end
            if (pksel[p] && samples_i[p].i_abs > imax)
            begin
               imax = samples_i[p].i_abs;
            end
            if (pkmon[p] && samples_i[p].v_abs > s_r.volt_thr)
            begin
               ev[IRQ_VPK] = 1'b1;
            end
            if (pkmon[p] && samples_i[p].i_abs > s_r.curr_thr)
            begin
               ev[IRQ_IPK] = 1'b1;
            end
         end
      end

      // Window sequencing; a zero count keeps the search idle
      unique case (s_r.win)
         WIN_IDLE:
         begin
            s_nxt.run_volt = '0;
            s_nxt.run_curr = '0;
            s_nxt.hc_seen = '0;
            if (s_r.half_cyc != '0)
            begin
               s_nxt.win = WIN_RUN;
            end
         end
         WIN_RUN:
         begin
            s_nxt.run_volt = vmax;
            s_nxt.run_curr = imax;
            if (half_cycle_i)
            begin
               s_nxt.hc_seen = s_r.hc_seen + HC_W'(1);
            end
            if (win_end)
            begin
               s_nxt.peak_volt = vmax;
               s_nxt.peak_curr = imax;
               s_nxt.run_volt = '0;
               s_nxt.run_curr = '0;
               s_nxt.hc_seen = '0;
               ev[IRQ_WIN] = 1'b1;
            end
            if (s_r.half_cyc == '0)
            begin
               s_nxt.win = WIN_IDLE;
            end
         end
         default: s_nxt.win = WIN_IDLE;
      endcase

      // Sticky status; a new event beats a clear in the same cycle
      s_nxt.stat = (s_r.stat & ~clr) | ev;
      s_nxt.irq = |(s_nxt.stat & s_nxt.en);

      // Sample strobe from the master clock divider
      if (s_r.div >= div_lim)
      begin
         s_nxt.div = '0;
         s_nxt.wave.strobe = 1'b1;
      end
      else
      begin
         s_nxt.div = s_r.div + DIV_W'(1);
         s_nxt.wave.strobe = 1'b0;
      end

      // Phase select, source select, reserved codes flagged
      s_nxt.wave.phase = s_nxt.wave_mode[SAMPLE_PHASE_SELECT_LSB +: 2];
      s_nxt.wave.source = s_nxt.wave_mode[SRC_LSB +: 3];
      s_nxt.wave.ok = (s_nxt.wave.phase != PH_RSVD) && (s_nxt.wave.source <= SRC_APP);
      s_nxt.pulse2_app = s_nxt.wave_mode[APPARENT_BIT];
   end

   // *****************************************************
   // State register
   // *****************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.meas_mode <= MEAS_MODE_RST;
         s_r.wave_mode <= WAVE_MODE_RST;
         s_r.win <= WIN_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;
   assign wave_o = s_r.wave;
   assign pulse2_apparent_o = s_r.pulse2_app;
   assign irq_o = s_r.irq;

   // *****************************************************
   // Checks
   // *****************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_pksel_reset: assert property ($past(rst_i)
      |-> pksel == PKSEL_RST && pkmon == PKSEL_RST)
      else $error("mode select fields not at reset value");
   chk_phase_a_peak: assert property (sample_valid_i && pksel[0]
      && s_r.win == WIN_RUN && !win_end |=> s_r.run_volt >= $past(samples_i[0].v_abs))
      else $error("phase A voltage not tracked");
   chk_window_publish: assert property (win_end && !sample_valid_i
      |=> s_r.peak_volt == $past(s_r.run_volt) && s_r.run_volt == '0 && s_r.stat[IRQ_WIN])
      else $error("peak not published at window end");
   // Peaks must not move between window ends, whatever software writes
   chk_peak_hold: assert property (!win_end
      |=> $stable(s_r.peak_volt) && $stable(s_r.peak_curr))
      else $error("peak changed inside a window");
   chk_phase_c_curr: assert property (sample_valid_i && pksel[2]
      && s_r.win == WIN_RUN && !win_end |=> s_r.run_curr >= $past(samples_i[2].i_abs))
      else $error("phase C current not tracked");
   chk_peak_gated: assert property (sample_valid_i && pksel == 3'h0
      && s_r.win == WIN_RUN |=> s_r.run_volt == $past(s_r.run_volt) || s_r.run_volt == '0)
      else $error("unselected phases moved the peak");
   chk_alarm_gated: assert property (sample_valid_i && pkmon == 3'h0
      && !s_r.stat[IRQ_VPK] |=> !s_r.stat[IRQ_VPK])
      else $error("unmonitored phase raised an alarm");
   chk_volt_alarm: assert property (sample_valid_i && pkmon[1]
      && samples_i[1].v_abs > s_r.volt_thr
      |=> s_r.stat[IRQ_VPK] ##0 (s_r.irq == s_r.en[IRQ_VPK] || s_r.irq))
      else $error("voltage threshold event lost");
   chk_curr_alarm: assert property (sample_valid_i && pkmon[1]
      && samples_i[1].i_abs > s_r.curr_thr |=> s_r.stat[IRQ_IPK])
      else $error("current threshold event lost");
   // Flag follows the stored code in the same cycle, so a fresh write may clear it at once
   chk_sel_reserved: assert property (s_r.wave_mode[SAMPLE_PHASE_SELECT_LSB +: 2] == PH_RSVD
      || s_r.wave_mode[SRC_LSB +: 3] > SRC_APP |-> !wave_o.ok)
      else $error("reserved selection flagged valid");
   chk_sel_follow: assert property ($changed(s_r.wave_mode) ##1 $stable(s_r.wave_mode)
      |-> wave_o.source == s_r.wave_mode[SRC_LSB +: 3])
      else $error("source output does not follow register");
   chk_rate_bound: assert property (wave_o.strobe |=> !wave_o.strobe [*8])
      else $error("sample strobe too frequent");
   chk_pulse_sel: assert property ($changed(s_r.wave_mode[APPARENT_BIT])
      |-> ##[0:1] pulse2_apparent_o == s_r.wave_mode[APPARENT_BIT])
      else $error("second pulse source lags");
   chk_bus_ack: assert property (bus_hit |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle");
   chk_irq_level: assert property (s_r.irq == |(s_r.stat & s_r.en))
      else $error("interrupt level does not match status");

   cov_window: cover property (win_end ##1 irq_o);
   cov_alarm: cover property (s_r.stat[IRQ_IPK] && s_r.stat[IRQ_VPK]);
   cov_slow_rate: cover property (wave_o.strobe && s_r.wave_mode[RATE_LSB +: 2] == 2'h3);
   cov_wave_write: cover property (bus_hit && wb_i.we && idx == IDX_WAVE_MODE);
   cov_reserved: cover property (!wave_o.ok);
endmodule : waveform_peak_mode_config

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb import waveform_peak_mode_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wb_req_s wb_i = '0;
   logic sample_valid_i = 1'b0;
   phase_sample_s [2:0] samples_i = '0;
   logic half_cycle_i = 1'b0;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   wave_sel_s wave_o;
   logic pulse2_apparent_o;
   logic irq_o;
   int err_count = 0;
   int n_checks = 0;
   logic [31:0] rd;

   waveform_peak_mode_config u_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_i(wb_i),
      .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o),
      .sample_valid_i(sample_valid_i),
      .samples_i(samples_i),
      .half_cycle_i(half_cycle_i),
      .wave_o(wave_o),
      .pulse2_apparent_o(pulse2_apparent_o),
      .irq_o(irq_o)
   );

   // Free running clock, 4 ns period
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // *****************************************
   // Shared tasks
   // *****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One classic cycle; waits for ack, never assumes its latency
   task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_i <= '{1'b1, 1'b1, we, {idx, 2'h0}, 4'hf, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      check({31'h0, wb_ack_o}, 32'h1);
      rd = wb_dat_o;
      wb_i <= '0;
      @(posedge clk_i); // Idle gap so ack has fallen
   endtask : wb

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      wb(1'b1, idx, d);
   endtask : wr

   task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h0);
      check(rd, exp);
   endtask : rdchk

   // One sample pulse; other phases read zero
   task automatic smp(input int p, input logic [23:0] v, input logic [23:0] i);
      phase_sample_s [2:0] s;
      s = '0;
      s[p] = '{v, i};
      @(posedge clk_i);
      samples_i <= s;
      sample_valid_i <= 1'b1;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
   endtask : smp

   task automatic hc;
      @(posedge clk_i);
      half_cycle_i <= 1'b1;
      @(posedge clk_i);
      half_cycle_i <= 1'b0;
   endtask : hc

   // *****************************************
   // Scenarios
   // *****************************************
   // reset defaults
   task automatic t_reset;
      rdchk(IDX_MEAS_MODE, 32'hfc);
      rdchk(IDX_WAVE_MODE, 32'h0);
      check({26'h0, wave_o.ok, wave_o.phase, wave_o.source}, 32'h20);
      check({31'h0, pulse2_apparent_o}, 32'h0);
      wr(6'h3f, 32'hff);
      rdchk(6'h3f, 32'h0);
   endtask : t_reset

   task automatic t_codes;
      logic [7:0] d;
      logic ok;
      for (int p = 0; p < 4; p++)
         for (int s = 0; s < 8; s++)
         begin
            d = {p[0], 2'h0, s[2:0], p[1:0]};
            ok = (p != 3) && (s < 5);
            wr(IDX_WAVE_MODE, {24'h0, d});
            rdchk(IDX_WAVE_MODE, {24'h0, d});
            check({26'h0, wave_o.ok, wave_o.phase, wave_o.source},
                  {26'h0, ok, p[1:0], s[2:0]});
            check({31'h0, pulse2_apparent_o}, {31'h0, p[0]});
         end
   endtask : t_codes

   task automatic t_rate;
      int n;
      for (int r = 0; r < 4; r++)
      begin
         wr(IDX_WAVE_MODE, {25'h0, r[1:0], 5'h0});
         // First gap may be odd after a change, so time the second
         for (int k = 0; k < 2; k++)
         begin
            n = 0;
            do
            begin
               @(posedge clk_i);
               n++;
            end
            while (wave_o.strobe !== 1'b1 && n < 4000);
         end
         check(n, PRE_DIV * (BASE_DIV << r));
      end
   endtask : t_rate

   task automatic t_peak;
      wr(IDX_HALF_CYC, 32'h1);
      wr(IDX_MEAS_MODE, 32'h08);
      hc();
      smp(0, 24'h900, 24'h900);
      smp(1, 24'h300, 24'h200);
      smp(1, 24'h100, 24'h400);
      smp(2, 24'h999, 24'h999);
      hc();
      rdchk(IDX_PEAK_VOLT, 32'h300);
      rdchk(IDX_PEAK_CURR, 32'h400);
      rdchk(IDX_IRQ_STAT, 32'h1 << IRQ_WIN);
      // Two half cycles per window: one pulse alone must not publish
      wr(IDX_HALF_CYC, 32'h2);
      wr(IDX_MEAS_MODE, 32'h14);
      hc();
      hc();
      smp(0, 24'h500, 24'h010);
      hc();
      rdchk(IDX_PEAK_VOLT, 32'h0);
      smp(2, 24'h020, 24'h600);
      smp(1, 24'h999, 24'h999);
      hc();
      rdchk(IDX_PEAK_VOLT, 32'h500);
      rdchk(IDX_PEAK_CURR, 32'h600);
      wr(IDX_PEAK_VOLT, 32'h0);
      rdchk(IDX_PEAK_VOLT, 32'h500);
      wr(IDX_HALF_CYC, 32'h0);
      wr(IDX_IRQ_CLR, 32'h7);
   endtask : t_peak

   task automatic t_alarm;
      wr(IDX_MEAS_MODE, 32'h40);
      wr(IDX_VOLT_THR, 32'h100);
      wr(IDX_CURR_THR, 32'h200);
      wr(IDX_IRQ_EN, 32'h1 << IRQ_VPK);
      rdchk(IDX_IRQ_EN, 32'h1 << IRQ_VPK);
      smp(0, 24'hfff, 24'hfff);
      smp(1, 24'h100, 24'h200);
      rdchk(IDX_IRQ_STAT, 32'h0);
      smp(1, 24'h0, 24'h201);
      @(posedge clk_i);
      check({31'h0, irq_o}, 32'h0);
      rdchk(IDX_IRQ_STAT, 32'h1 << IRQ_IPK);
      smp(1, 24'h101, 24'h0);
      @(posedge clk_i);
      check({31'h0, irq_o}, 32'h1);
      wr(IDX_IRQ_CLR, 32'h1 << IRQ_VPK);
      check({31'h0, irq_o}, 32'h0);
      rdchk(IDX_IRQ_STAT, 32'h1 << IRQ_IPK);
   endtask : t_alarm

   // *****************************************
   // Verdict and sequencing
   // *****************************************
   task automatic results;
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // Main sequence after a 16 cycle reset
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_codes();
      t_rate();
      t_peak();
      t_alarm();
      results();
   end

   // Watchdog, well past the longest rate test
   initial
   begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      results();
   end
endmodule : tb
